// [common/rlp_defs.vh]
// Constants for the twelve-channel LED sink controller core.
// Assumes inclusion by bare name from the rtl files.
`ifndef RLP_DEFS_VH
`define RLP_DEFS_VH
`define RLP_ADDR_FIXED 5'h13
`define RLP_STRAP_GND 2'h0
`define RLP_STRAP_SCL 2'h1
`define RLP_STRAP_SDA 2'h2
`define RLP_STRAP_VCC 2'h3
`define RLP_MODE_PWM 2'h0
`define RLP_MODE_LEVEL 2'h1
`define RLP_MODE_PATTERN 2'h2
`define RLP_PFS_220 2'h0
`define RLP_PFS_440 2'h1
`define RLP_CORE_HZ 10000000
`define RLP_OSC_LO_HZ 1800000
`define RLP_OSC_HI_HZ 6000000
`define RLP_DIV_LO ((`RLP_CORE_HZ + `RLP_OSC_LO_HZ - 1) / `RLP_OSC_LO_HZ)
`define RLP_DIV_HI ((`RLP_CORE_HZ + `RLP_OSC_HI_HZ - 1) / `RLP_OSC_HI_HZ)
`define RLP_RAMP_MAX_S 10
`define RLP_RAMP_TICK_HZ 1000
`define RLP_RAMP_TICK_DIV (`RLP_CORE_HZ / `RLP_RAMP_TICK_HZ)
`define RLP_RAMP_MAX_TICKS (`RLP_RAMP_MAX_S * `RLP_RAMP_TICK_HZ)
`define RLP_GCC_RESET 6'h3F
`define RLP_REG_BYTES 256
`define RLP_REG_MODE 8'h04
`define RLP_REG_GCC 8'h07
`define RLP_REG_LEVEL 8'h10
`define RLP_REG_COLOR2 8'h20
`define RLP_REG_COLOR3 8'h30
`define RLP_REG_PWM 8'h40
`endif

// [rtl/rlp_i2c_target.v]
// I2C-compatible target: start/stop detection, address match, byte writes and reads.
// Assumes SCL and SDA inputs are already synchronised to CORE_CLK.
`timescale 1ns/1ns
`include "rlp_defs.vh"
module rlp_i2c_target (
    input wire clk,
    input wire rst,
    input wire clr,
    input wire scl,
    input wire sda,
    input wire [1:0] strap,
    output reg sda_oe_n,
    output reg wr_stb,
    output reg [7:0] wr_addr,
    output reg [7:0] wr_data,
    output wire [7:0] rd_addr,
    input wire [7:0] rd_data
);
    localparam S_IDLE = 3'h0;
    localparam S_ADDR = 3'h1;
    localparam S_REG = 3'h2;
    localparam S_WDAT = 3'h3;
    localparam S_RDAT = 3'h4;
    localparam S_IGN = 3'h5;
    reg scl_d, sda_d;
    reg [2:0] state;
    reg [3:0] bitc;
    reg [7:0] shift;
    reg [7:0] ptr;
    reg ack_phase, reading, mack;
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start = scl & scl_d & sda_d & ~sda;
    wire stop = scl & scl_d & ~sda_d & sda;
    assign rd_addr = ptr;
    always @(posedge clk) begin
        scl_d <= scl;
        sda_d <= sda;
        wr_stb <= 1'b0;
        if (rst || clr || stop) begin
            state <= S_IDLE;
            sda_oe_n <= 1'b1;
            bitc <= 4'h0;
            ack_phase <= 1'b0;
            reading <= 1'b0;
            mack <= 1'b0;
            if (rst) begin
                ptr <= 8'h00;
                shift <= 8'h00;
                wr_addr <= 8'h00;
                wr_data <= 8'h00;
            end
        end else if (start) begin
            state <= S_ADDR;
            bitc <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (state != S_IDLE && state != S_IGN) begin
            if (scl_rise && !ack_phase) begin
                shift <= {shift[6:0], sda | (state == S_RDAT)};
                bitc <= bitc + 4'h1;
                if (state == S_RDAT)
                    mack <= 1'b0;
            end else if (scl_rise && ack_phase && state == S_RDAT) begin
                mack <= ~sda;
            end
            if (scl_fall) begin
                if (!ack_phase && bitc == 4'h8) begin
                    bitc <= 4'h0;
                    ack_phase <= 1'b1;
                    case (state)
                        S_ADDR: begin
                            if (shift[7:1] == {`RLP_ADDR_FIXED, strap}) begin
                                sda_oe_n <= 1'b0;
                                reading <= shift[0];
                            end else begin
                                state <= S_IGN;
                            end
                        end
                        S_REG: begin
                            sda_oe_n <= 1'b0;
                            ptr <= shift;
                        end
                        S_WDAT: begin
                            sda_oe_n <= 1'b0;
                            wr_stb <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shift;
                            ptr <= ptr + 8'h01;
                        end
                        S_RDAT: begin
                            sda_oe_n <= 1'b1;
                            ptr <= ptr + 8'h01;
                        end
                        default: begin
                            sda_oe_n <= 1'b1;
                        end
                    endcase
                end else if (ack_phase) begin
                    ack_phase <= 1'b0;
                    case (state)
                        S_ADDR: begin
                            state <= reading ? S_RDAT : S_REG;
                            shift <= rd_data;
                            sda_oe_n <= reading ? rd_data[7] : 1'b1;
                            bitc <= 4'h0;
                        end
                        S_REG: begin
                            state <= S_WDAT;
                            sda_oe_n <= 1'b1;
                        end
                        S_WDAT: begin
                            sda_oe_n <= 1'b1;
                        end
                        S_RDAT: begin
                            if (mack) begin
                                shift <= rd_data;
                                sda_oe_n <= rd_data[7];
                                bitc <= 4'h0;
                            end else begin
                                state <= S_IGN;
                                sda_oe_n <= 1'b1;
                            end
                        end
                        default: begin
                            sda_oe_n <= 1'b1;
                        end
                    endcase
                end else if (state == S_RDAT) begin
                    sda_oe_n <= shift[7];
                end
            end
        end
    end
endmodule

// [rtl/rlp_led_core.v]
// Top of the twelve-channel LED sink controller: serial target, register file, PWM and patterns.
// Assumes serial, strap, shutdown and cascade pins arrive asynchronously to CORE_CLK; analog sinks take the digital outputs.
//
// Overview of operation
// - Target address is 10011 followed by two strapped bits, in byte bits seven to one.
// - Lowest address-byte bit selects direction: zero writes, one reads.
// - Strap pin tied to ground, clock, data or supply gives 00, 01, 10, 11.
// - Serial clock is input only; data line is only pulled low, open drain.
// - Serial interface works up to 1MHz; controller must not exceed that.
// - While shutdown pin is low the device stays shut down, outputs inactive.
// - Each rising edge of the shutdown pin returns the serial logic to idle.
// - Each channel has 4096-step PWM from 12 bits and 256-step current from 8 bits.
// - One 6-bit, 64-step global current scale applies to every output.
// - PWM mode gates the output by 12-bit PWM, amplitude from 8-bit level.
// - Current-level mode uses only the 8-bit level, without PWM gating.
// - Pattern mode runs four breathing engines cycling through three colours alone.
// - Fade-in and fade-out ramps can last up to ten seconds; here each way runs 4.08s up to about 32.6s.
// - Frequency code 00 gives 220Hz, 01 gives 440Hz, 1x gives 23kHz with 8+4 bits; here about 407Hz, 814Hz and 19.5kHz, low 4 bits undithered.
// - Timebase is 1.8MHz for 12-bit settings, 6MHz for the 8+4-bit setting; here about 1.67MHz and 5MHz.
// - Low-current accuracy option cuts full-scale current to one tenth.
// - Cascade pin carries sync clock in or out, or the breathing mark when enabled; the code never uses the clock input.
// - Writes are address, register address, data bytes, MSB first, each acknowledged.
// - Register pointer increments by one at each data-byte acknowledge.
// - Reads set the pointer by a write, then repeated start with direction one.
`timescale 1ns/1ns
`include "rlp_defs.vh"
module rlp_led_core #(
    parameter CHANNELS = 12,
    parameter RAMP_TICK_DIV = `RLP_RAMP_TICK_DIV
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire RST,
    // Serial pins
    input wire SCL_IN,
    input wire SDA_IN,
    output wire SDA_OE_N,
    // Strap and shutdown
    input wire ADDR_STRAP_SCL,
    input wire ADDR_STRAP_SDA,
    input wire ADDR_STRAP_VCC,
    input wire SHUTDOWN_N_PIN,
    // Configuration
    input wire [1:0] PWM_FREQ_SELECT,
    input wire LOW_CURRENT_ACCURACY_OPTION,
    input wire FULL_SCALE_CURRENT_SELECT,
    input wire CASCADE_MASTER,
    input wire BREATH_MARK_ENABLE,
    input wire [6:0] RAMP_TIME,
    // Cascade pin
    input wire CASCADE_CLOCK_MARK_PIN_IN,
    output reg CASCADE_CLOCK_MARK_PIN_OUT,
    output reg CASCADE_CLOCK_MARK_PIN_OE_N,
    // Channel outputs
    output reg [CHANNELS-1:0] SINK_CHANNEL_OUTPUTS,
    output reg [CHANNELS*8-1:0] SINK_CHANNEL_AMPLITUDE,
    output reg [5:0] GLOBAL_CURRENT_CODE,
    output reg FULL_SCALE_TENTH,
    output reg SHUTDOWN_ACTIVE
);
    reg [1:0] s_scl, s_sda, s_sdn, s_cas, s_st1, s_st2, s_st3;
    wire scl = s_scl[1];
    wire sda = s_sda[1];
    wire sdn = s_sdn[1];
    reg sdn_d;
    wire sdn_rise = sdn & ~sdn_d;
    reg [1:0] strap;
    reg [7:0] regs [0:`RLP_REG_BYTES-1];
    wire wr_stb;
    wire [7:0] wr_addr, wr_data, rd_addr;
    reg [7:0] rd_data;
    reg [2:0] osc_cnt;
    reg osc_en;
    reg [11:0] pwm_cnt;
    reg [14:0] tick_cnt;
    reg [3:0] tick_sub;
    reg ramp_tick;
    reg [7:0] breath [0:3];
    reg [3:0] fall;
    reg [1:0] color [0:3];
    reg [6:0] hold [0:3];
    reg [5:0] global_current_code;
    integer i;
    localparam integer DIV_HI_LAST = `RLP_DIV_HI - 1;
    localparam integer DIV_LO_LAST = `RLP_DIV_LO - 1;
    localparam integer TICK_LAST = RAMP_TICK_DIV - 1;
    function [7:0] reg_of;
        input [7:0] base;
        input integer ch;
        begin
            reg_of = base + ch[7:0];
        end
    endfunction
    always @(posedge CORE_CLK) begin
        s_scl <= {s_scl[0], SCL_IN};
        s_sda <= {s_sda[0], SDA_IN};
        s_sdn <= {s_sdn[0], SHUTDOWN_N_PIN};
        s_cas <= {s_cas[0], CASCADE_CLOCK_MARK_PIN_IN};
        s_st1 <= {s_st1[0], ADDR_STRAP_SCL};
        s_st2 <= {s_st2[0], ADDR_STRAP_SDA};
        s_st3 <= {s_st3[0], ADDR_STRAP_VCC};
        sdn_d <= sdn;
    end
    // The strap is sampled only in shutdown and at its release, so a glitch on SCL or SDA cannot move the address.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            strap <= `RLP_STRAP_GND;
        end else if (sdn_rise || !sdn) begin
            if (s_st3[1])
                strap <= `RLP_STRAP_VCC;
            else if (s_st2[1])
                strap <= `RLP_STRAP_SDA;
            else if (s_st1[1])
                strap <= `RLP_STRAP_SCL;
            else
                strap <= `RLP_STRAP_GND;
        end
    end
    // Sampling at 10MHz covers a 1MHz serial clock with about five samples per phase.
    rlp_i2c_target u_target (
        .clk(CORE_CLK),
        .rst(RST),
        .clr(sdn_rise),
        .scl(scl),
        .sda(sda),
        .strap(strap),
        .sda_oe_n(SDA_OE_N),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );
    always @(posedge CORE_CLK) begin
        if (wr_stb)
            regs[wr_addr] <= wr_data;
        rd_data <= regs[rd_addr];
    end
    always @(posedge CORE_CLK) begin
        if (RST) begin
            global_current_code <= `RLP_GCC_RESET;
        end else if (wr_stb && wr_addr == `RLP_REG_GCC) begin
            global_current_code <= wr_data[5:0];
        end
    end
    // Oscillator enable: every 6 or 2 core cycles, 1.67MHz or 5MHz for 1.8MHz or 6MHz; the 10MHz core limits accuracy.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            osc_cnt <= 3'h0;
            osc_en <= 1'b0;
        end else begin
            osc_en <= 1'b0;
            if (osc_cnt == 3'h0) begin
                osc_en <= 1'b1;
                osc_cnt <= PWM_FREQ_SELECT[1] ? DIV_HI_LAST[2:0] : DIV_LO_LAST[2:0];
            end else begin
                osc_cnt <= osc_cnt - 3'h1;
            end
        end
    end
    // 440Hz halves the 220Hz period by stepping two; 23kHz steps by 16, running the top 8 bits with no dithering of the low 4.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            pwm_cnt <= 12'h000;
        end else if (osc_en) begin
            case (PWM_FREQ_SELECT)
                `RLP_PFS_220: pwm_cnt <= pwm_cnt + 12'h001;
                `RLP_PFS_440: pwm_cnt <= pwm_cnt + 12'h002;
                default: pwm_cnt <= pwm_cnt + 12'h010;
            endcase
        end
    end
    always @(posedge CORE_CLK) begin
        if (RST) begin
            tick_cnt <= 15'h0000;
            ramp_tick <= 1'b0;
            tick_sub <= 4'h0;
        end else begin
            ramp_tick <= 1'b0;
            if (tick_cnt == TICK_LAST[14:0]) begin
                tick_cnt <= 15'h0000;
                tick_sub <= tick_sub + 4'h1;
                ramp_tick <= (tick_sub == 4'h0);
            end else begin
                tick_cnt <= tick_cnt + 15'h0001;
            end
        end
    end
    // Four breathing engines: 255 steps each way, one per 1 + RAMP_TIME/16 ticks of 16ms; up to about 32.6s.
    always @(posedge CORE_CLK) begin
        if (RST || !sdn) begin
            for (i = 0; i < 4; i = i + 1) begin
                breath[i] <= 8'h00;
                fall[i] <= 1'b0;
                color[i] <= 2'h0;
                hold[i] <= 7'h00;
            end
        end else if (ramp_tick) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (hold[i] != 7'h00) begin
                    hold[i] <= hold[i] - 7'h01;
                end else begin
                    hold[i] <= RAMP_TIME >> 4;
                    if (!fall[i]) begin
                        breath[i] <= breath[i] + 8'h01;
                        if (breath[i] == 8'hFE)
                            fall[i] <= 1'b1;
                    end else begin
                        breath[i] <= breath[i] - 8'h01;
                        if (breath[i] == 8'h01) begin
                            fall[i] <= 1'b0;
                            color[i] <= (color[i] == 2'h2) ? 2'h0 : color[i] + 2'h1;
                        end
                    end
                end
            end
        end
    end
    always @(posedge CORE_CLK) begin
        if (RST) begin
            SINK_CHANNEL_OUTPUTS <= {CHANNELS{1'b0}};
            SINK_CHANNEL_AMPLITUDE <= {CHANNELS*8{1'b0}};
            GLOBAL_CURRENT_CODE <= 6'h00;
            FULL_SCALE_TENTH <= 1'b0;
            SHUTDOWN_ACTIVE <= 1'b1;
        end else begin
            SHUTDOWN_ACTIVE <= ~sdn;
            GLOBAL_CURRENT_CODE <= sdn ? global_current_code : 6'h00;
            FULL_SCALE_TENTH <= LOW_CURRENT_ACCURACY_OPTION;
            for (i = 0; i < CHANNELS; i = i + 1) begin
                if (!sdn) begin
                    SINK_CHANNEL_OUTPUTS[i] <= 1'b0;
                    SINK_CHANNEL_AMPLITUDE[i*8 +: 8] <= 8'h00;
                end else begin
                    case (regs[`RLP_REG_MODE + i[7:0] / 4][(i % 4) * 2 +: 2])
                        `RLP_MODE_PWM: begin
                            SINK_CHANNEL_OUTPUTS[i] <= pwm_cnt <
                                {regs[reg_of(`RLP_REG_PWM, 2 * i + 1)][3:0],
                                 regs[reg_of(`RLP_REG_PWM, 2 * i)]};
                            SINK_CHANNEL_AMPLITUDE[i*8 +: 8] <= regs[reg_of(`RLP_REG_LEVEL, i)];
                        end
                        `RLP_MODE_LEVEL: begin
                            SINK_CHANNEL_OUTPUTS[i] <= 1'b1;
                            SINK_CHANNEL_AMPLITUDE[i*8 +: 8] <= regs[reg_of(`RLP_REG_LEVEL, i)];
                        end
                        `RLP_MODE_PATTERN: begin
                            SINK_CHANNEL_OUTPUTS[i] <= pwm_cnt[11:4] < breath[i / 3];
                            SINK_CHANNEL_AMPLITUDE[i*8 +: 8] <= regs[reg_of(
                                color[i / 3] == 2'h0 ? `RLP_REG_LEVEL :
                                color[i / 3] == 2'h1 ? `RLP_REG_COLOR2 : `RLP_REG_COLOR3, i)];
                        end
                        default: begin
                            SINK_CHANNEL_OUTPUTS[i] <= 1'b0;
                            SINK_CHANNEL_AMPLITUDE[i*8 +: 8] <= 8'h00;
                        end
                    endcase
                end
            end
        end
    end
    // The pin drives only as master or as mark; as slave it is an input.
    always @(posedge CORE_CLK) begin
        if (RST) begin
            CASCADE_CLOCK_MARK_PIN_OUT <= 1'b0;
            CASCADE_CLOCK_MARK_PIN_OE_N <= 1'b1;
        end else if (BREATH_MARK_ENABLE) begin
            CASCADE_CLOCK_MARK_PIN_OUT <= fall[0];
            CASCADE_CLOCK_MARK_PIN_OE_N <= 1'b0;
        end else begin
            CASCADE_CLOCK_MARK_PIN_OUT <= pwm_cnt[11];
            CASCADE_CLOCK_MARK_PIN_OE_N <= ~(CASCADE_MASTER & sdn);
        end
    end
endmodule

// [testbench/rlp_i2c_ctrl_model.sv]
// Bus controller model: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the data wire with a pull-up; the core clock paces every phase.
`timescale 1ns/1ns
module rlp_i2c_ctrl_model (
    // Clock
    input wire clk,
    // Bus
    input wire sda,
    output reg scl,
    output reg sda_low
);
    integer slow;
    reg held;
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
        slow = 0;
        held = 1'h0;
    end
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Five core cycles per phase keep the bus at 1MHz at most.
    task start;
        begin
            if (held) begin
                tick(2);
                sda_low <= 1'h0;
                tick(3);
                scl <= 1'h1;
                tick(5);
            end
            held = 1'h1;
            sda_low <= 1'h1;
            tick(5);
            scl <= 1'h0;
        end
    endtask
    task stop;
        begin
            tick(2);
            sda_low <= 1'h1;
            tick(3);
            scl <= 1'h1;
            tick(5);
            sda_low <= 1'h0;
            held = 1'h0;
            tick(5);
        end
    endtask
    task xfer(input [7:0] d, input last, output [7:0] q, output ack);
        integer i;
        reg [8:0] tx;
        begin
            tx = {d, last};
            for (i = 8; i >= 0; i = i - 1) begin
                tick(3 + slow);
                sda_low <= ~tx[i];
                tick(2);
                scl <= 1'h1;
                tick(5);
                if (i > 0)
                    q[i - 1] = sda;
                else
                    ack = ~sda;
                scl <= 1'h0;
            end
        end
    endtask
endmodule

// [testbench/rlp_led_core_asserts.sv]
// Concurrent checks on the pins of the LED sink controller core.
// Assumes it is bound to rlp_led_core and sees only that module's ports.
`timescale 1ns/1ns
module rlp_led_core_asserts #(
    parameter CHANNELS = 12
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire RST,
    // Serial pins
    input wire SCL_IN,
    input wire SDA_IN,
    input wire SDA_OE_N,
    // Shutdown and options
    input wire SHUTDOWN_N_PIN,
    input wire LOW_CURRENT_ACCURACY_OPTION,
    // Outputs
    input wire [CHANNELS-1:0] SINK_CHANNEL_OUTPUTS,
    input wire [5:0] GLOBAL_CURRENT_CODE,
    input wire FULL_SCALE_TENTH,
    input wire SHUTDOWN_ACTIVE
);
    reg in_frame;
    reg scl_d;
    reg sda_d;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Frames are seen on the raw pins, ahead of the core's synchroniser, so this bound is loose.
    always @(posedge CORE_CLK) begin
        scl_d <= SCL_IN;
        sda_d <= SDA_IN;
        if (RST)
            in_frame <= 1'h0;
        else if (scl_d && SCL_IN && sda_d && !SDA_IN)
            in_frame <= 1'h1;
        else if (scl_d && SCL_IN && !sda_d && SDA_IN)
            in_frame <= 1'h0;
    end
    reset_state_a: assert property (disable iff (1'h0) RST |=> SDA_OE_N && SHUTDOWN_ACTIVE
        && SINK_CHANNEL_OUTPUTS == '0 && GLOBAL_CURRENT_CODE == 6'h00)
        else $error("state after reset wrong");
    sda_edge_a: assert property ($fell(SDA_OE_N) |-> !$past(SCL_IN))
        else $error("data line pulled while clock high");
    ack_hold_a: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*4])
        else $error("data line drive too short");
    frame_only_a: assert property (!SDA_OE_N |-> in_frame)
        else $error("data line pulled outside a frame");
    shut_quiet_a: assert property (!SHUTDOWN_N_PIN [*6] |-> SHUTDOWN_ACTIVE)
        else $error("shutdown pin low but core active");
    dark_shutdown_a: assert property (SHUTDOWN_ACTIVE [*2] |-> SINK_CHANNEL_OUTPUTS == '0)
        else $error("outputs on during shutdown");
    shut_release_a: assert property ($rose(SHUTDOWN_N_PIN) |-> ##[1:8] (SDA_OE_N && !SHUTDOWN_ACTIVE))
        else $error("no wake to idle after shutdown pin rise");
    tenth_follow_a: assert property ($stable(LOW_CURRENT_ACCURACY_OPTION) [*5]
        |-> FULL_SCALE_TENTH == LOW_CURRENT_ACCURACY_OPTION)
        else $error("full scale tenth does not follow option");
    gcc_write_a: assert property ($changed(GLOBAL_CURRENT_CODE)
        |-> in_frame || $changed(SHUTDOWN_ACTIVE))
        else $error("global code changed outside a frame");
    cover property ($fell(SDA_OE_N));
    cover property ($rose(SHUTDOWN_N_PIN));
    cover property ($changed(GLOBAL_CURRENT_CODE));
endmodule
bind rlp_led_core rlp_led_core_asserts #(.CHANNELS(CHANNELS)) u_chk (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN),
    .SDA_OE_N(SDA_OE_N),
    .SHUTDOWN_N_PIN(SHUTDOWN_N_PIN),
    .LOW_CURRENT_ACCURACY_OPTION(LOW_CURRENT_ACCURACY_OPTION),
    .SINK_CHANNEL_OUTPUTS(SINK_CHANNEL_OUTPUTS),
    .GLOBAL_CURRENT_CODE(GLOBAL_CURRENT_CODE),
    .FULL_SCALE_TENTH(FULL_SCALE_TENTH),
    .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE)
);

// [testbench/rlp_led_core_bench.sv]
// Self-checking bench for the LED sink controller core driven by a bus controller model.
// Assumes the checker is bound to the core and a pull-up holds the data line.
`timescale 1ns/1ns
module rlp_led_core_bench;
    reg core_clk = 1'h0, rst = 1'h1, shut_n = 1'h1;
    reg low_current_accuracy_option, strap_scl, strap_sda, strap_vcc, fsc, cas_master, breath_en, cas_in;
    reg [1:0] pwm_freq;
    reg [6:0] ramp;
    wire scl, sda_low, sda_oe_n, cas_out, cas_oe_n, tenth, shut_act;
    wire [11:0] outs;
    wire [95:0] amp;
    wire [5:0] gcc_out;
    wire sda_line = (sda_oe_n === 1'h0 || sda_low) ? 1'h0 : 1'h1;
    integer seed = 79167, n_fail = 0, comparisons = 0, cycles = 0, s, i;
    reg [31:0] r;
    reg [6:0] dev_addr;
    reg [7:0] q;
    reg ack, on0, on4;
    reg [5:0] global_current_code;
    reg [7:0] wbuf [0:7];
    reg [7:0] rbuf [0:7];
    rlp_led_core #(.CHANNELS(12), .RAMP_TICK_DIV(10)) u_dut (
        .CORE_CLK(core_clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OE_N(sda_oe_n),
        .ADDR_STRAP_SCL(strap_scl), .ADDR_STRAP_SDA(strap_sda), .ADDR_STRAP_VCC(strap_vcc),
        .SHUTDOWN_N_PIN(shut_n), .PWM_FREQ_SELECT(pwm_freq),
        .LOW_CURRENT_ACCURACY_OPTION(low_current_accuracy_option), .FULL_SCALE_CURRENT_SELECT(fsc),
        .CASCADE_MASTER(cas_master), .BREATH_MARK_ENABLE(breath_en), .RAMP_TIME(ramp),
        .CASCADE_CLOCK_MARK_PIN_IN(cas_in), .CASCADE_CLOCK_MARK_PIN_OUT(cas_out),
        .CASCADE_CLOCK_MARK_PIN_OE_N(cas_oe_n), .SINK_CHANNEL_OUTPUTS(outs),
        .SINK_CHANNEL_AMPLITUDE(amp), .GLOBAL_CURRENT_CODE(gcc_out),
        .FULL_SCALE_TENTH(tenth), .SHUTDOWN_ACTIVE(shut_act));
    rlp_i2c_ctrl_model u_mdl (.clk(core_clk), .sda(sda_line), .scl(scl), .sda_low(sda_low));
    always #50 core_clk = ~core_clk;
    task complete_run;
        begin
            if (n_fail == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            n_fail = n_fail + 1;
            complete_run;
        end
    end
    task check_val(input string what, input [95:0] exp, input [95:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0s expected %0h seen %0h", what, exp, got);
            end
        end
    endtask
    task send_head(input [6:0] a, input [7:0] ra);
        begin
            u_mdl.start;
            u_mdl.xfer({a, 1'h0}, 1'h1, q, ack);
            check_val("address ack", 1'h1, ack);
            u_mdl.xfer(ra, 1'h1, q, ack);
            check_val("register ack", 1'h1, ack);
        end
    endtask
    task write_regs(input [7:0] ra, input integer n);
        begin
            send_head(dev_addr, ra);
            for (i = 0; i < n; i = i + 1) begin
                u_mdl.xfer(wbuf[i], 1'h1, q, ack);
                check_val("data ack", 1'h1, ack);
            end
            u_mdl.stop;
        end
    endtask
    task read_regs(input [7:0] ra, input integer n);
        begin
            send_head(dev_addr, ra);
            u_mdl.start;
            u_mdl.xfer({dev_addr, 1'h1}, 1'h1, q, ack);
            check_val("read ack", 1'h1, ack);
            for (i = 0; i < n; i = i + 1)
                u_mdl.xfer(8'hFF, i == n - 1, rbuf[i], ack);
            u_mdl.stop;
        end
    endtask
    initial begin
        r = $random(seed);
        {low_current_accuracy_option, strap_scl, strap_sda, strap_vcc, fsc, cas_master} <= r[5:0];
        {breath_en, cas_in, pwm_freq, ramp} <= r[16:6];
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        u_mdl.tick(6);
        check_val("global code", 6'h3F, gcc_out);
        check_val("data release", 1'h1, sda_oe_n);
        for (s = 0; s < 4; s = s + 1) begin
            r = $random(seed);
            {low_current_accuracy_option, pwm_freq, fsc, cas_master, breath_en, cas_in, ramp} <= r[15:2];
            strap_vcc <= (s == 3);
            strap_sda <= (s == 2) | ((s == 3) & r[0]);
            strap_scl <= (s == 1) | ((s >= 2) & r[1]);
            shut_n <= 1'h0;
            u_mdl.tick(8);
            check_val("shutdown flag", 1'h1, shut_act);
            shut_n <= 1'h1;
            u_mdl.tick(10);
            check_val("shutdown flag", 1'h0, shut_act);
            dev_addr = {5'h13, s[1:0]};
            send_head(dev_addr, 8'h07);
            u_mdl.stop;
            u_mdl.start;
            u_mdl.xfer({5'h13, s[1:0] + 2'h1, 1'h0}, 1'h1, q, ack);
            check_val("foreign address ack", 1'h0, ack);
            u_mdl.stop;
        end
        global_current_code = $random(seed);
        global_current_code = global_current_code | 6'h01;
        {wbuf[0], wbuf[1], wbuf[2], wbuf[3]} = {8'h55, 16'h0000, 2'h0, global_current_code};
        write_regs(8'h04, 4);
        check_val("global code", global_current_code, gcc_out);
        {wbuf[0], wbuf[1]} = 16'h0000;
        write_regs(8'h48, 2);
        for (s = 0; s < 5; s = s + 1)
            wbuf[s] = $random(seed) | 8'h01;
        write_regs(8'h10, 5);
        read_regs(8'h10, 5);
        for (s = 0; s < 5; s = s + 1)
            check_val("level readback", wbuf[s], rbuf[s]);
        u_mdl.tick(1000);
        {on0, on4} = 2'h2;
        repeat (500) begin
            @(posedge core_clk);
            on0 = on0 & outs[0];
            on4 = on4 | outs[4];
        end
        check_val("level mode gate", 1'h1, on0);
        check_val("zero duty gate", 1'h0, on4);
        check_val("level amplitude", wbuf[0], amp[7:0]);
        check_val("pwm amplitude", wbuf[4], amp[39:32]);
        check_val("cascade drive", !(breath_en | cas_master), cas_oe_n);
        read_regs(8'h04, 4);
        check_val("mode readback", 8'h55, rbuf[0]);
        check_val("global readback", {2'h0, global_current_code}, rbuf[3]);
        low_current_accuracy_option <= 1'h1;
        u_mdl.tick(6);
        check_val("full scale tenth", 1'h1, tenth);
        shut_n <= 1'h0;
        u_mdl.tick(8);
        check_val("outputs in shutdown", 12'h000, outs);
        shut_n <= 1'h1;
        u_mdl.tick(10);
        send_head(dev_addr, 8'h07);
        shut_n <= 1'h0;
        u_mdl.tick(10);
        shut_n <= 1'h1;
        u_mdl.tick(10);
        u_mdl.xfer({2'h0, ~global_current_code}, 1'h1, q, ack);
        check_val("ack after wake", 1'h0, ack);
        u_mdl.stop;
        check_val("global code", global_current_code, gcc_out);
        u_mdl.slow = 7;
        wbuf[0] = {2'h0, ~global_current_code};
        write_regs(8'h07, 1);
        read_regs(8'h07, 1);
        u_mdl.slow = 0;
        check_val("global readback", wbuf[0], rbuf[0]);
        check_val("global code", wbuf[0], gcc_out);
        complete_run;
    end
endmodule
